// File: src/rs_gen_params.svh
`ifndef RS_GEN_PARAMS_SVH
`define RS_GEN_PARAMS_SVH

// register word indexes; byte address is four times the index
`define RS_IDX_MODE         8'h00
`define RS_IDX_SETPOINT     8'h02
`define RS_IDX_PV           8'h03
`define RS_IDX_FLAGS        8'h33
`define RS_IDX_TABLE_PTR    8'h34
`define RS_IDX_TABLE_BASE   8'h40

// profile table storage
`define RS_TABLE_WORDS      64
`define RS_TABLE_AW         6
`define RS_PAIRS            8
`define RS_LAST_PAIR        3'h7
`define RS_OFS_END          2'h0
`define RS_OFS_RATE         2'h1
`define RS_OFS_SOAK         2'h2
`define RS_OFS_DEV          2'h3

// flag word and mode word fields
`define RS_BIT_START        0
`define RS_BIT_HOLD         1
`define RS_BIT_RESUME       2
`define RS_BIT_JOG          3
`define RS_BIT_COMPLETE     4
`define RS_BIT_DEVIATION    5
`define RS_BIT_HELD         6
`define RS_STEP_LSB         8
`define RS_MODE_ENABLE_BIT  11

// ramp rate is hundredths of counts per second, added once per tick
`define RS_RATE_SCALE       15'h2710

// timing
`define RS_CLK_PERIOD_NS    50
`define RS_TICK_PERIOD_NS   10000000
`define RS_TICK_CYCLES      (`RS_TICK_PERIOD_NS / `RS_CLK_PERIOD_NS)
`define RS_TICK_CNT_W       18
`define RS_TICK_MS          10
`define RS_TENTH_MIN_MS     6000
`define RS_TICKS_PER_TENTH  (`RS_TENTH_MIN_MS / `RS_TICK_MS)

`endif

// File: src/rs_gen_pkg.sv
`include "rs_gen_params.svh"

package rs_gen_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RAMP = 4'h2,
    ST_SOAK = 4'h4,
    ST_DONE = 4'h8
  } gen_state_t;

  typedef struct packed {
    gen_state_t                                  state;
    logic                                        held;
    logic                                        dirUp;
    logic [2:0]                                  pair;
    logic [7:0]                                  segNum;
    logic [3:0]                                  cmd;
    logic                                        complete;
    logic                                        devAlarm;
    logic [15:0]                                 setpoint;
    logic [15:0]                                 pv;
    logic [15:0]                                 mode;
    logic [`RS_TABLE_AW-1:0]                     tablePtr;
    logic [13:0]                                 frac;
    logic [13:0]                                 soakLeft;
    logic [9:0]                                  tenthCnt;
    logic [`RS_TICK_CNT_W-1:0]                   tickCnt;
    logic [`RS_TABLE_WORDS-1:0][15:0]            profMem;
    logic                                        ack;
    logic [31:0]                                 rdata;
  } gen_regs_t;

endpackage : rs_gen_pkg

// File: src/ramp_soak_generator.sv
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "rs_gen_params.svh"

// Contract
// - profile holds at most eight ramp/soak pairs, sixteen segments.
// - one generator per loop; instantiate per loop, use is optional via enable.
// - runs whenever controller is in Run, whether loop is Manual or Auto.
// - segments numbered 1 to 16; odd are ramps, even are soaks.
// - ramp direction from end value compared with setpoint at ramp start.
// - soak holds setpoint at value reached by preceding ramp.
// - table base comes from pointer word at loop offset 34.
// - each pair is four words: end, rate, soak time, deviation limit.
// - ramp end value is target setpoint in setpoint format.
// - ramp rate is BCD 00.00 to 99.99 counts per second.
// - soak time is BCD 000.1 to 999.9 minutes.
// - during soak, flag deviation when PV leaves setpoint plus/minus limit.
// - ramp starts after previous soak; first ramp starts from present setpoint.
// - profile ends when next pair's ramp rate is zero.
// - table words are fetched when used, not cached at start.
// - start, hold, resume and jog commands are accepted in real time.
// - completion, soak deviation and current segment reported to software.
// - commands and status share the flag word at loop offset 33.
// - flag bits 0..3 command on 0-to-1; controller clears them after reading.
// - hold freezes; resume only from hold; jog ends segment early.
// - bit 4 complete, bit 5 deviation, bit 6 held, bits 15:8 segment.
// - mode bit 11 enables; other controls work only while it stays 1.
module ramp_soak_generator #(
  parameter int unsigned TICK_CYCLES = `RS_TICK_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        plcRun,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  output var  logic [15:0] setpointWord
);

  rs_gen_pkg::gen_regs_t r;
  rs_gen_pkg::gen_regs_t next_r;

  function automatic logic [13:0] bcdToBin(input logic [15:0] b);
    return 14'(b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0]);
  endfunction : bcdToBin

  // pair * 4 + word, offset from the table pointer, wrapping in the table
  function automatic logic [`RS_TABLE_AW-1:0] wordAddr(
    input logic [`RS_TABLE_AW-1:0] ptr,
    input logic [2:0]              p,
    input logic [1:0]              k
  );
    return ptr + `RS_TABLE_AW'({p, k});
  endfunction : wordAddr

  function automatic logic [15:0] laneMerge(
    input logic [15:0] old,
    input logic [31:0] d,
    input logic [3:0]  sel
  );
    return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : laneMerge

  always_comb begin
    logic        req;
    logic [7:0]  idx;
    logic        active;
    logic        tick;
    logic        reached;
    logic        endRamp;
    logic        endSoak;
    logic [2:0]  nxtPair;
    logic [15:0] curEnd;
    logic [15:0] curRate;
    logic [15:0] curSoak;
    logic [15:0] curDev;
    logic [15:0] nxtEnd;
    logic [15:0] nxtRate;
    logic [15:0] firstEnd;
    logic [15:0] firstRate;
    logic [15:0] diff;
    logic [14:0] fsum;
    logic [15:0] wv;
    logic [15:0] rword;
    req       = wb_cyc_i & wb_stb_i & ~r.ack;
    idx       = wb_adr_i[9:2];
    active    = plcRun & r.mode[`RS_MODE_ENABLE_BIT];
    tick      = (r.tickCnt == `RS_TICK_CNT_W'(TICK_CYCLES - 1));
    reached   = 1'b0;
    endRamp   = 1'b0;
    endSoak   = 1'b0;
    nxtPair   = r.pair + 3'h1;
    // fetched live each time they are used, so edits take effect mid-profile
    curEnd    = r.profMem[wordAddr(r.tablePtr, r.pair, `RS_OFS_END)];
    curRate   = r.profMem[wordAddr(r.tablePtr, r.pair, `RS_OFS_RATE)];
    curSoak   = r.profMem[wordAddr(r.tablePtr, r.pair, `RS_OFS_SOAK)];
    curDev    = r.profMem[wordAddr(r.tablePtr, r.pair, `RS_OFS_DEV)];
    nxtEnd    = r.profMem[wordAddr(r.tablePtr, nxtPair, `RS_OFS_END)];
    nxtRate   = r.profMem[wordAddr(r.tablePtr, nxtPair, `RS_OFS_RATE)];
    firstEnd  = r.profMem[wordAddr(r.tablePtr, 3'h0, `RS_OFS_END)];
    firstRate = r.profMem[wordAddr(r.tablePtr, 3'h0, `RS_OFS_RATE)];
    diff      = (r.setpoint >= r.pv) ? r.setpoint - r.pv : r.pv - r.setpoint;
    fsum      = 15'({1'b0, r.frac}) + 15'(bcdToBin(curRate));
    wv        = 16'h0000;
    rword     = 16'h0000;

    next_r     = r;
    next_r.ack = req;
    next_r.tickCnt = tick ? '0 : r.tickCnt + `RS_TICK_CNT_W'(1);

    if (!active) begin
      // dropping the enable or leaving Run abandons the profile
      next_r.state    = rs_gen_pkg::ST_IDLE;
      next_r.held     = 1'b0;
      next_r.devAlarm = 1'b0;
    end else begin
      if (r.cmd[`RS_BIT_START]) begin
        next_r.pair     = 3'h0;
        next_r.held     = 1'b0;
        next_r.frac     = 14'h0000;
        next_r.complete = 1'b0;
        if (firstRate == 16'h0000) begin
          next_r.state    = rs_gen_pkg::ST_DONE;
          next_r.complete = 1'b1;
          next_r.segNum   = 8'h00;
        end else begin
          next_r.state  = rs_gen_pkg::ST_RAMP;
          next_r.segNum = 8'h01;
          next_r.dirUp  = firstEnd > r.setpoint;
        end
      end else if (r.cmd[`RS_BIT_HOLD]) begin
        if (r.state == rs_gen_pkg::ST_RAMP || r.state == rs_gen_pkg::ST_SOAK) begin
          next_r.held = 1'b1;
        end
      end else if (r.cmd[`RS_BIT_RESUME]) begin
        next_r.held = 1'b0;
      end else if (r.cmd[`RS_BIT_JOG]) begin
        endRamp = (r.state == rs_gen_pkg::ST_RAMP);
        endSoak = (r.state == rs_gen_pkg::ST_SOAK);
      end else if (tick && !r.held) begin
        case (r.state)
          rs_gen_pkg::ST_RAMP: begin
            reached = r.dirUp ? (r.setpoint >= curEnd) : (r.setpoint <= curEnd);
            if (reached) begin
              next_r.setpoint = curEnd;
              endRamp         = 1'b1;
            end else if (fsum >= `RS_RATE_SCALE) begin
              // at most one count per tick, so the step can never pass the end
              next_r.frac     = 14'(fsum - `RS_RATE_SCALE);
              next_r.setpoint = r.dirUp ? r.setpoint + 16'h0001 : r.setpoint - 16'h0001;
            end else begin
              next_r.frac = fsum[13:0];
            end
          end
          rs_gen_pkg::ST_SOAK: begin
            if (r.soakLeft == 14'h0000) begin
              endSoak = 1'b1;
            end else if (r.tenthCnt == 10'(`RS_TICKS_PER_TENTH - 1)) begin
              next_r.tenthCnt = 10'h000;
              next_r.soakLeft = r.soakLeft - 14'h0001;
            end else begin
              next_r.tenthCnt = r.tenthCnt + 10'h001;
            end
          end
          default: begin
            next_r.state = r.state;
          end
        endcase
      end

      if (endRamp) begin
        // setpoint is left where the ramp stopped for the whole soak
        next_r.state    = rs_gen_pkg::ST_SOAK;
        next_r.segNum   = r.segNum + 8'h01;
        next_r.soakLeft = bcdToBin(curSoak);
        next_r.tenthCnt = 10'h000;
      end

      if (endSoak) begin
        if (r.pair == `RS_LAST_PAIR || nxtRate == 16'h0000) begin
          next_r.state    = rs_gen_pkg::ST_DONE;
          next_r.complete = 1'b1;
        end else begin
          next_r.state  = rs_gen_pkg::ST_RAMP;
          next_r.pair   = nxtPair;
          next_r.segNum = r.segNum + 8'h01;
          next_r.dirUp  = nxtEnd > r.setpoint;
          next_r.frac   = 14'h0000;
        end
      end

      // a zero limit leaves the alarm off, the limit being optional
      next_r.devAlarm = (r.state == rs_gen_pkg::ST_SOAK) && (curDev != 16'h0000)
                        && (diff > curDev);
      next_r.cmd = 4'h0;
    end

    case (idx)
      `RS_IDX_MODE:      rword = r.mode;
      `RS_IDX_SETPOINT:  rword = r.setpoint;
      `RS_IDX_PV:        rword = r.pv;
      `RS_IDX_FLAGS:     rword = {r.segNum, 1'b0, r.held, r.devAlarm, r.complete, r.cmd};
      `RS_IDX_TABLE_PTR: rword = {10'h000, r.tablePtr};
      default: begin
        if (idx[7:6] == 2'(`RS_IDX_TABLE_BASE >> 6)) begin
          rword = r.profMem[idx[5:0]];
        end else begin
          rword = 16'h0000;
        end
      end
    endcase
    wv = laneMerge(rword, wb_dat_i, wb_sel_i);

    if (req) begin
      next_r.rdata = {16'h0000, rword};
    end

    if (req && wb_we_i) begin
      case (idx)
        `RS_IDX_MODE:      next_r.mode = wv;
        // a software write lands on top of the generator's value
        `RS_IDX_SETPOINT:  next_r.setpoint = wv;
        `RS_IDX_PV:        next_r.pv = wv;
        // a command written as the controller clears it survives
        `RS_IDX_FLAGS:     next_r.cmd = wv[3:0];
        `RS_IDX_TABLE_PTR: next_r.tablePtr = wv[`RS_TABLE_AW-1:0];
        default: begin
          if (idx[7:6] == 2'(`RS_IDX_TABLE_BASE >> 6)) begin
            next_r.profMem[idx[5:0]] = wv;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r       <= '0;
      r.state <= rs_gen_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign wb_ack_o     = r.ack;
  assign wb_dat_o     = r.rdata;
  assign setpointWord = r.setpoint;

endmodule : ramp_soak_generator
`default_nettype wire

// File: bench/ramp_soak_generator_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ramp_soak_generator_monitor (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        plcRun,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [15:0] setpointWord
);
  logic       take;
  logic       rd;
  logic       spWr;
  logic [7:0] ix;
  assign ix = wb_adr_i[9:2];
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd = take && !wb_we_i;
  assign spWr = take && wb_we_i && ix == 8'h02;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ack_next_a: assert property (take |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_cause_a: assert property (wb_ack_o |-> $past(take)) else $error("stray ack");
  rdata_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved");
  flag_spare_a: assert property ($past(rd && ix == 8'h33)
    |-> !wb_dat_o[7] && wb_dat_o[31:16] == 16'h0000) else $error("spare flag bits set");
  sp_readback_a: assert property ($past(rd && ix == 8'h02)
    |-> wb_dat_o[15:0] == $past(setpointWord)) else $error("setpoint readback wrong");
  // a table edit in mid-ramp may legally jump; the bench never does that
  sp_step_a: assert property (!$past(spWr)
    |-> setpointWord - $past(setpointWord) inside {16'h0000, 16'h0001, 16'hFFFF})
    else $error("setpoint jumped");
  sp_idle_a: assert property ($past(!plcRun) && !$past(spWr) |-> $stable(setpointWord))
    else $error("setpoint moved while stopped");
endmodule : ramp_soak_generator_monitor

bind ramp_soak_generator ramp_soak_generator_monitor mon (
  .mclk(mclk), .sys_rst(sys_rst), .plcRun(plcRun), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .setpointWord(setpointWord)
);
`default_nettype wire

// File: bench/ramp_soak_generator_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ramp_soak_generator_tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        run = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] datO;
  logic        ack;
  logic [15:0] sp;
  logic [31:0] rdat;
  logic [31:0] r1;
  logic [43:0] op;
  logic [63:0] note;
  logic [63:0] noteQ[$];
  int          errors = 0;
  int          samplesChecked = 0;
  int          seed = 32'hF699;
  int          i;
  // kind, index, data or mask, expected
  logic [43:0] ops[47] = '{
    44'h0_00_0000_0000, 44'h0_02_0000_0000, 44'h0_03_0000_0000,
    44'h0_33_0000_0000, 44'h0_34_0000_0000,
    44'h1_34_FFFF_0000, 44'h0_34_0000_003F,
    44'h1_33_00F0_0000, 44'h0_33_0000_0000,
    44'h1_02_0100_0000, 44'h1_03_0100_0000, 44'h1_7C_0103_0000, 44'h1_7D_5000_0000,
    44'h1_7E_0001_0000, 44'h1_7F_0002_0000, 44'h1_40_00FE_0000, 44'h1_41_9999_0000,
    44'h1_45_0000_0000, 44'h1_34_003C_0000,
    44'h1_33_0001_0000, 44'h0_33_0000_0001,
    44'h1_00_0800_0000, 44'h2_00_FF00_0200,
    44'h0_02_0000_0103,
    44'h0_33_0000_0220,
    44'h1_03_0101_0000, 44'h0_33_0000_0200,
    44'h1_33_0002_0000, 44'h0_33_0000_0240,
    44'h1_33_0004_0000, 44'h0_33_0000_0200,
    44'h1_33_0008_0000, 44'h0_33_0000_0300,
    44'h2_00_0010_0010, 44'h0_33_0000_0410,
    44'h0_02_0000_00FE,
    44'h1_33_0002_0000, 44'h0_33_0000_0410,
    44'h1_34_0004_0000, 44'h1_33_0001_0000, 44'h0_33_0000_0010,
    44'h1_34_003C_0000, 44'h1_33_0001_0000, 44'h3_00_0000_00FE, 44'h0_33_0000_0100,
    44'h0_02_0000_00FE, 44'h3_00_0001_00FE
  };

  // short tick keeps a tenth-minute soak at 2400 cycles
  ramp_soak_generator #(.TICK_CYCLES(4)) uut (
    .mclk(mclk), .sys_rst(rst), .plcRun(run), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO),
    .wb_ack_o(ack), .setpointWord(sp)
  );

  always #25 mclk = ~mclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("errors=%0d checks=%0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic giveUp;
    errors++;
    print_verdict();
  endtask : giveUp

  // mask 0 marks a poll whose data is only looked at by the driver
  task automatic bus(input logic w, input logic [7:0] ix, input logic [15:0] d,
                     input logic [31:0] e = 32'h0, input logic [31:0] m = 32'hFFFF_FFFF,
                     input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    if (!w) noteQ.push_back({m, e});
    @(posedge mclk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, ix, 2'b00, s, 16'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rdat = datO;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) giveUp();
  endtask : bus

  task automatic waitFlag(input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do begin
      bus(1'b0, 8'h33, 16'h0, 32'h0, 32'h0);
      k++;
    end while ((rdat & m) !== v && k < 3000);
    if ((rdat & m) !== v) giveUp();
  endtask : waitFlag

  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      note = noteQ.pop_front();
      if (note[63:32] != 32'h0) check(datO & note[63:32], note[31:0]);
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    foreach (ops[k]) begin
      op = ops[k];
      case (op[43:40])
        4'h0: bus(1'b0, op[39:32], 16'h0, {16'h0, op[15:0]});
        4'h1: bus(1'b1, op[39:32], op[31:16]);
        4'h2: waitFlag({16'h0, op[31:16]}, {16'h0, op[15:0]});
        default: begin
          run <= op[16];
          repeat (8) @(posedge mclk);
          check({16'h0, sp}, {16'h0, op[15:0]});
        end
      endcase
    end
    for (i = 0; i < 3; i++) begin
      r1 = $random(seed);
      bus(1'b1, 8'h48 + i[7:0], r1[15:0]);
      bus(1'b0, 8'h48 + i[7:0], 16'h0, {16'h0, r1[15:0]});
    end
    bus(1'b1, 8'h03, r1[31:16], 32'h0, 32'h0, 4'h2);
    bus(1'b0, 8'h03, 16'h0, {16'h0, r1[31:24], 8'h01});
    bus(1'b1, 8'h01, r1[15:0]);
    bus(1'b0, 8'h01, 16'h0, 32'h0);
    print_verdict();
  end
endmodule : ramp_soak_generator_tb
`default_nettype wire
